// File: common/tcp_cfg.svh
// Constants for the TLP transmit and credit port pair
// Notes on behaviour
// - User cancels only the final beat, never with last
// - Cancel ends TLP at once as nullified
// - Half-beat flag marks only bits 63:32 valid
// - Downgraded link gates beats by clock enable
// - Header credit: bit 8 unlimited, 7:0 count
// - Data credit: bit 12 unlimited, 11:0 count
// - User ignores count when unlimited flag set
// - Counts drop on send, rise on updates
// - Credits added only by flow-control update
// - Posted send pulses posted-credit-changed
// - Completion send pulses completion-credit-changed
// - Waiting user rechecks credits on changed pulse
// - 64-bit bus: byte N in 63:56 downward
// - First beat follows grant by one cycle
// - Request may stay high over a burst
// - Everything runs on the one 125 MHz clock
// - 16-bit bus: byte N in 15:8
`ifndef TCP_CFG_SVH
`define TCP_CFG_SVH
`define TCP_CLK_MHZ        125
`define TCP_DATA_W         64
`define TCP_DOWN_DIV       4
`define TCP_HDR_INF_BIT    8
`define TCP_DATA_INF_BIT   12
`define TCP_OFF_CMD        4'h0
`define TCP_OFF_STATUS     4'h4
`define TCP_OFF_CREDIT     4'h8
`define TCP_OFF_RXWORD     4'hC
`define TCP_CMD_KIND_LSB   0
`define TCP_CMD_BEATS_LSB  2
`define TCP_CMD_CANCEL_BIT 10
`define TCP_CMD_START_BIT  11
`define TCP_CMD_HALF_BIT   12
`endif

// File: common/tcp_if.sv
// Interface joining the core end and the user end of the TLP port
`timescale 1ns/100ps
interface tcp_if #(parameter int DW = 64);
	logic                     tlp_send_request;
	logic                     tlp_send_grant;
	logic                     tlp_first_beat_in;
	logic                     tlp_last_beat_in;
	logic                     tlp_cancel_in;
	logic                     tx_upper_half_only;
	logic [DW-1:0]            transmit_tlp_word;
	tcp_pkg::tcp_kind_t       tlp_kind;
	logic [7:0]               hdr_need;
	logic [11:0]              data_need;
	logic                     beat_enable;
	tcp_pkg::tcp_hdr_avail_t  header_credit_avail;
	tcp_pkg::tcp_data_avail_t data_credit_avail;
	logic                     posted_credit_changed;
	logic                     completion_credit_changed;
	logic [DW-1:0]            receive_tlp_word;
	logic                     receive_valid;
	modport core (
		input  tlp_send_request, tlp_first_beat_in, tlp_last_beat_in,
		input  tlp_cancel_in, tx_upper_half_only, transmit_tlp_word,
		input  tlp_kind, hdr_need, data_need,
		output tlp_send_grant, beat_enable, header_credit_avail,
		output data_credit_avail, posted_credit_changed,
		output completion_credit_changed, receive_tlp_word, receive_valid
	);
	modport user (
		output tlp_send_request, tlp_first_beat_in, tlp_last_beat_in,
		output tlp_cancel_in, tx_upper_half_only, transmit_tlp_word,
		output tlp_kind, hdr_need, data_need,
		input  tlp_send_grant, beat_enable, header_credit_avail,
		input  data_credit_avail, posted_credit_changed,
		input  completion_credit_changed, receive_tlp_word, receive_valid
	);
endinterface : tcp_if

// File: common/tcp_pkg.sv
// Shared types for the TLP transmit and credit port pair
package tcp_pkg;
	typedef enum logic [1:0] {KIND_P, KIND_NP, KIND_CPL, KIND_NONE} tcp_kind_t;
	typedef enum logic [1:0] {CS_IDLE, CS_WAIT, CS_DATA} tcp_core_st_t;
	typedef enum logic [1:0] {US_IDLE, US_CRED, US_REQ, US_SEND} tcp_user_st_t;
	typedef logic [2:0][8:0]  tcp_hdr_avail_t;
	typedef logic [2:0][12:0] tcp_data_avail_t;
endpackage : tcp_pkg

// File: hdl/tcp_core.sv
// Core end: credit bookkeeping, send grant, beat gating, byte ordering
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "tcp_cfg.svh"
module tcp_core #(
	parameter int DW       = `TCP_DATA_W,
	parameter int DOWN_DIV = `TCP_DOWN_DIV
) (
	// Clock and reset
	input  wire logic          CLK,
	input  wire logic          RST,
	// User side of the TLP port
	tcp_if.core                b,
	// Link width state
	input  wire logic          LINK_DOWNGRADED,
	// Flow-control update arriving from the link
	input  wire logic          FC_UPDATE,
	input  wire logic [1:0]    FC_KIND,
	input  wire logic [7:0]    FC_HDR_ADD,
	input  wire logic [11:0]   FC_DATA_ADD,
	input  wire logic          FC_HDR_INF,
	input  wire logic          FC_DATA_INF,
	// Receive words from the link, byte N in the low byte
	input  wire logic          LINK_RX_VALID,
	input  wire logic [DW-1:0] LINK_RX_WORD,
	// Transmit beats to the link, byte N in the low byte
	output logic               LINK_TX_VALID,
	output logic [DW-1:0]      LINK_TX_WORD,
	output logic               LINK_TX_LAST,
	output logic               LINK_TX_ABORT,
	output logic               LINK_TX_HALF
);
	localparam int NB = DW / 8;
	localparam int CW = (DOWN_DIV > 1) ? $clog2(DOWN_DIV) : 1;
	localparam logic [CW-1:0] DIV_LAST = CW'(DOWN_DIV - 1);

	typedef struct packed {
		tcp_pkg::tcp_core_st_t st;
		logic [CW-1:0]         div;
		logic                  beat_en;
		logic                  grant;
		tcp_pkg::tcp_kind_t    kind;
		logic [7:0]            hneed;
		logic [11:0]           dneed;
		logic [2:0][7:0]       hcnt;
		logic [2:0][11:0]      dcnt;
		logic [2:0]            hinf;
		logic [2:0]            dinf;
		logic                  p_chg;
		logic                  c_chg;
		logic                  tx_valid;
		logic [DW-1:0]         tx_word;
		logic                  tx_last;
		logic                  tx_abort;
		logic                  tx_half;
		logic                  rx_valid;
		logic [DW-1:0]         rx_word;
	} tcp_core_state_t;

	tcp_core_state_t r;
	tcp_core_state_t n;

	// Byte N moves between the low byte and the top byte
	// Same map serves both directions and any whole byte width
	function automatic logic [DW-1:0] swap_bytes(input logic [DW-1:0] w);
		logic [DW-1:0] o;
		o = '0;
		for (int i = 0; i < NB; i++) begin
			o[(NB-1-i)*8 +: 8] = w[i*8 +: 8];
		end
		return o;
	endfunction : swap_bytes

	function automatic logic fits(input logic inf, input logic [11:0] avail,
	                              input logic [11:0] need);
		return inf || (avail >= need);
	endfunction : fits

	// Counts wrap rather than saturate; a sane partner never overflows
	function automatic logic [11:0] cnt_next(input logic [11:0] cur,
	                                         input logic [11:0] add,
	                                         input logic [11:0] sub);
		return cur + add - sub;
	endfunction : cnt_next

	logic [1:0] k;
	logic       ok;
	logic       debit;
	logic [7:0] hsub;
	logic [11:0] dsub;
	logic [7:0] hadd;
	logic [11:0] dadd;

	always_comb begin
		n = r;
		k = b.tlp_kind;
		debit = 1'b0;
		n.grant = 1'b0;
		n.p_chg = 1'b0;
		n.c_chg = 1'b0;
		n.tx_valid = 1'b0;
		n.tx_last = 1'b0;
		n.tx_abort = 1'b0;
		n.tx_half = 1'b0;
		// Enable every cycle at full width, one in DOWN_DIV when narrowed
		if (!LINK_DOWNGRADED || r.div == DIV_LAST) begin
			n.div = '0;
		end else begin
			n.div = r.div + 1'b1;
		end
		n.beat_en = !LINK_DOWNGRADED || (n.div == '0);
		// Kind 3 is the idle code and is never granted
		ok = (k != 2'd3)
			&& fits(r.hinf[k], {4'h0, r.hcnt[k]}, {4'h0, b.hdr_need})
			&& fits(r.dinf[k], r.dcnt[k], b.data_need);
		case (r.st)
			tcp_pkg::CS_IDLE: begin
				// Grant is a pulse, so it is low between TLPs of a burst
				if (b.tlp_send_request && ok && !r.grant) begin
					n.grant = 1'b1;
					// Needs latched here; the debit ignores later changes
					n.kind = b.tlp_kind;
					n.hneed = b.hdr_need;
					n.dneed = b.data_need;
					n.st = tcp_pkg::CS_WAIT;
				end
			end
			tcp_pkg::CS_WAIT, tcp_pkg::CS_DATA: begin
				// After the first beat, every enabled cycle carries a beat
				if (r.beat_en && (b.tlp_first_beat_in
				    || r.st == tcp_pkg::CS_DATA)) begin
					n.tx_valid = 1'b1;
					n.tx_word = swap_bytes(b.transmit_tlp_word);
					n.tx_half = (DW == 64) && b.tx_upper_half_only;
					n.st = tcp_pkg::CS_DATA;
					if (b.tlp_cancel_in) begin
						// Nullified: no credits consumed, link drops it
						n.tx_abort = 1'b1;
						n.st = tcp_pkg::CS_IDLE;
					end else if (b.tlp_last_beat_in) begin
						// Debit only on the last beat
						n.tx_last = 1'b1;
						n.st = tcp_pkg::CS_IDLE;
						debit = 1'b1;
					end
				end
			end
			default: n.st = tcp_pkg::CS_IDLE;
		endcase
		for (int t = 0; t < 3; t++) begin
			hsub = '0;
			dsub = '0;
			hadd = '0;
			dadd = '0;
			// Unlimited kinds are never debited, so never pulse
			if (debit && r.kind == tcp_pkg::tcp_kind_t'(t)) begin
				hsub = r.hinf[t] ? 8'h00 : r.hneed;
				dsub = r.dinf[t] ? 12'h000 : r.dneed;
			end
			// Only an update from the link adds credits
			if (FC_UPDATE && FC_KIND == 2'(t)) begin
				hadd = FC_HDR_ADD;
				dadd = FC_DATA_ADD;
				n.hinf[t] = FC_HDR_INF;
				n.dinf[t] = FC_DATA_INF;
			end
			// An update and a debit in one cycle both apply
			n.hcnt[t] = 8'(cnt_next({4'h0, r.hcnt[t]}, {4'h0, hadd},
			                        {4'h0, hsub}));
			n.dcnt[t] = cnt_next(r.dcnt[t], dadd, dsub);
			if (hsub != '0 || dsub != '0) begin
				// One-cycle pulse only when a nonzero debit is taken
				if (t == 0) n.p_chg = 1'b1;
				if (t == 2) n.c_chg = 1'b1;
			end
		end
		// Receive path has no backpressure: one word per valid
		n.rx_valid = LINK_RX_VALID;
		if (LINK_RX_VALID) begin
			n.rx_word = swap_bytes(LINK_RX_WORD);
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			// Idle kind, so a stray last beat debits nothing
			r <= '0;
			r.kind <= tcp_pkg::KIND_NONE;
		end else begin
			r <= n;
		end
	end

	assign b.tlp_send_grant = r.grant;
	assign b.beat_enable = r.beat_en;
	assign b.posted_credit_changed = r.p_chg;
	assign b.completion_credit_changed = r.c_chg;
	assign b.receive_tlp_word = r.rx_word;
	assign b.receive_valid = r.rx_valid;
	// Unlimited flag sits above each count
	always_comb begin
		for (int t = 0; t < 3; t++) begin
			b.header_credit_avail[t] = {r.hinf[t], r.hcnt[t]};
			b.data_credit_avail[t] = {r.dinf[t], r.dcnt[t]};
		end
	end
	assign LINK_TX_VALID = r.tx_valid;
	assign LINK_TX_WORD = r.tx_word;
	assign LINK_TX_LAST = r.tx_last;
	assign LINK_TX_ABORT = r.tx_abort;
	assign LINK_TX_HALF = r.tx_half;
endmodule : tcp_core

// File: hdl/tcp_user.sv
// User end: Avalon-MM command registers driving TLP sends
`timescale 1ns/100ps
`include "tcp_cfg.svh"
module tcp_user #(
	parameter int DW = `TCP_DATA_W
) (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// Core side of the TLP port
	tcp_if.user              b,
	// Avalon-MM slave
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST
);
	typedef struct packed {
		tcp_pkg::tcp_user_st_t st;
		logic                  wait_n;
		logic [31:0]           rdata;
		tcp_pkg::tcp_kind_t    kind;
		logic [7:0]            beats;
		logic [7:0]            left;
		logic                  cancel;
		logic                  half;
		logic [7:0]            sent;
		logic [31:0]           rxw;
		logic                  req;
		logic                  first;
		logic                  last;
		logic                  nul;
		logic                  hflag;
		logic [DW-1:0]         word;
	} tcp_user_state_t;

	tcp_user_state_t r;
	tcp_user_state_t n;
	logic [1:0] k;
	logic       ok;
	logic       chg;
	logic       acc;

	always_comb begin
		n = r;
		k = r.kind;
		// Unlimited flag overrides the count
		ok = (k != 2'd3)
			&& (b.header_credit_avail[k][`TCP_HDR_INF_BIT]
			|| b.header_credit_avail[k][7:0] != 8'h00)
			&& (b.data_credit_avail[k][`TCP_DATA_INF_BIT]
			|| b.data_credit_avail[k][11:0] >= {4'h0, r.beats});
		chg = (k == 2'd0 && b.posted_credit_changed)
			|| (k == 2'd2 && b.completion_credit_changed);
		// Answer one cycle after the request; waitrequest high otherwise
		acc = (AVS_READ || AVS_WRITE) && !r.wait_n;
		n.wait_n = acc;
		if (acc && AVS_READ) begin
			if (AVS_ADDRESS == `TCP_OFF_STATUS) begin
				n.rdata = {16'h0000, r.sent, 6'h00, r.nul,
				           r.st != tcp_pkg::US_IDLE};
			end else if (AVS_ADDRESS == `TCP_OFF_CREDIT) begin
				n.rdata = {10'h000, b.data_credit_avail[k],
				           b.header_credit_avail[k]};
			end else if (AVS_ADDRESS == `TCP_OFF_RXWORD) begin
				n.rdata = r.rxw;
			end else begin
				n.rdata = 32'h0000_0000;
			end
		end
		if (b.receive_valid) begin
			n.rxw = b.receive_tlp_word[DW-1 -: 32];
		end
		case (r.st)
			tcp_pkg::US_IDLE: begin
				if (r.wait_n && AVS_WRITE && AVS_ADDRESS == `TCP_OFF_CMD
				    && AVS_WRITEDATA[`TCP_CMD_START_BIT]
				    && AVS_WRITEDATA[`TCP_CMD_BEATS_LSB +: 8] != 8'h00) begin
					n.kind = tcp_pkg::tcp_kind_t'(
						AVS_WRITEDATA[`TCP_CMD_KIND_LSB +: 2]);
					n.beats = AVS_WRITEDATA[`TCP_CMD_BEATS_LSB +: 8];
					n.cancel = AVS_WRITEDATA[`TCP_CMD_CANCEL_BIT];
					n.half = AVS_WRITEDATA[`TCP_CMD_HALF_BIT];
					n.st = tcp_pkg::US_CRED;
				end
			end
			tcp_pkg::US_CRED: begin
				if (ok) begin
					n.req = 1'b1;
					n.st = tcp_pkg::US_REQ;
				end
			end
			tcp_pkg::US_REQ: begin
				if (b.tlp_send_grant) begin
					n.first = 1'b1;
					n.left = r.beats;
					n.word = {(DW/8){8'h00}};
					n.last = (r.beats == 8'h01) && !r.cancel;
					n.nul = (r.beats == 8'h01) && r.cancel;
					n.hflag = (r.beats == 8'h01) && r.half && (DW == 64);
					n.st = tcp_pkg::US_SEND;
				end else if (chg && !ok) begin
					n.req = 1'b0;
					n.st = tcp_pkg::US_CRED;
				end
			end
			tcp_pkg::US_SEND: begin
				// Beats advance only on enabled cycles
				if (b.beat_enable) begin
					n.first = 1'b0;
					n.left = r.left - 8'h01;
					n.word = {(DW/8){8'(r.beats - r.left + 8'h01)}};
					if (r.last || r.nul) begin
						n.req = 1'b0;
						n.last = 1'b0;
						n.nul = 1'b0;
						n.hflag = 1'b0;
						n.sent = r.sent + 8'h01;
						n.st = tcp_pkg::US_IDLE;
					end else begin
						// Cancel replaces the last marker, never both
						n.last = (r.left == 8'h02) && !r.cancel;
						n.nul = (r.left == 8'h02) && r.cancel;
						n.hflag = (r.left == 8'h02) && r.half && (DW == 64);
					end
				end
			end
			default: n.st = tcp_pkg::US_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			r <= '0;
			r.kind <= tcp_pkg::KIND_NONE;
		end else begin
			r <= n;
		end
	end

	assign AVS_READDATA = r.rdata;
	assign AVS_WAITREQUEST = !r.wait_n;
	assign b.tlp_send_request = r.req;
	assign b.tlp_first_beat_in = r.first;
	assign b.tlp_last_beat_in = r.last;
	assign b.tlp_cancel_in = r.nul;
	assign b.tx_upper_half_only = r.hflag;
	assign b.transmit_tlp_word = r.word;
	assign b.tlp_kind = r.kind;
	assign b.hdr_need = 8'h01;
	assign b.data_need = {4'h0, r.beats};
endmodule : tcp_user

// File: verification/tb.sv
// Bench joining core and user ends, driven over Avalon-MM
`timescale 1ns/100ps
`include "tcp_cfg.svh"
module tb;
	localparam int DIV = 4;
	logic        CLK, RST, LINK_DOWNGRADED, FC_UPDATE, FC_HDR_INF;
	logic        FC_DATA_INF, LINK_RX_VALID, LINK_TX_VALID, LINK_TX_ABORT;
	logic        LINK_TX_HALF, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
	logic        LINK_TX_LAST;
	logic [1:0]  FC_KIND;
	logic [7:0]  FC_HDR_ADD;
	logic [11:0] FC_DATA_ADD;
	logic [3:0]  AVS_ADDRESS;
	logic [63:0] LINK_RX_WORD, LINK_TX_WORD, tx_w;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
	int          bad_count, check_count, n_val, n_abt, n_half, n_p, n_c;
	int          n_en, e0, n_last;
	tcp_if #(.DW(64)) bus ();
	tcp_core #(.DW(64), .DOWN_DIV(DIV)) u_tcp_core (.CLK, .RST, .b(bus),
		.LINK_DOWNGRADED, .FC_UPDATE, .FC_KIND, .FC_HDR_ADD, .FC_DATA_ADD,
		.FC_HDR_INF, .FC_DATA_INF, .LINK_RX_VALID, .LINK_RX_WORD,
		.LINK_TX_VALID, .LINK_TX_WORD, .LINK_TX_LAST, .LINK_TX_ABORT,
		.LINK_TX_HALF);
	tcp_user #(.DW(64)) u_tcp_user (.CLK, .RST, .b(bus), .AVS_ADDRESS,
		.AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA,
		.AVS_WAITREQUEST);
	tcp_props u_tcp_props (.CLK, .RST,
		.tlp_send_request(bus.tlp_send_request),
		.tlp_send_grant(bus.tlp_send_grant),
		.tlp_first_beat_in(bus.tlp_first_beat_in),
		.tlp_last_beat_in(bus.tlp_last_beat_in),
		.tlp_cancel_in(bus.tlp_cancel_in), .beat_enable(bus.beat_enable),
		.tlp_kind(bus.tlp_kind), .hdr_need(bus.hdr_need),
		.data_need(bus.data_need),
		.header_credit_avail(bus.header_credit_avail),
		.data_credit_avail(bus.data_credit_avail),
		.posted_credit_changed(bus.posted_credit_changed),
		.completion_credit_changed(bus.completion_credit_changed));
	always #4 CLK = ~CLK;
	always @(posedge CLK) begin
		if (!RST) begin
			n_val  <= n_val + LINK_TX_VALID;
			n_abt  <= n_abt + LINK_TX_ABORT;
			n_half <= n_half + LINK_TX_HALF;
			n_p    <= n_p + bus.posted_credit_changed;
			n_c    <= n_c + bus.completion_credit_changed;
			n_en   <= n_en + bus.beat_enable;
			n_last <= n_last + LINK_TX_LAST;
			if (LINK_TX_VALID) begin
				tx_w <= LINK_TX_WORD;
			end
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge CLK);
		{AVS_ADDRESS, AVS_WRITE, AVS_READ, AVS_WRITEDATA} <= {a, w, !w, d};
		do @(posedge CLK);
		while (AVS_WAITREQUEST !== 1'h0);
		rd = AVS_READDATA;
		{AVS_WRITE, AVS_READ} <= 2'h0;
	endtask : xfer
	task automatic fc(input logic [1:0] k, input logic [7:0] h,
		input logic [11:0] d, input logic inf);
		@(posedge CLK);
		{FC_UPDATE, FC_KIND, FC_HDR_ADD, FC_DATA_ADD} <= {1'h1, k, h, d};
		{FC_HDR_INF, FC_DATA_INF} <= {inf, inf};
		@(posedge CLK);
		FC_UPDATE <= 1'h0;
		@(posedge CLK);
	endtask : fc
	task automatic cmd(input logic [1:0] k, input logic [7:0] nb,
		input logic cx, input logic hf);
		xfer(1'h1, `TCP_OFF_CMD, {19'h0, hf, 1'h1, cx, nb, k});
	endtask : cmd
	// Polls until the send is over; the watchdog bounds a hang
	task automatic idle;
		do xfer(1'h0, `TCP_OFF_STATUS, 32'h0);
		while (rd[0] !== 1'h0);
	endtask : idle
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	initial begin
		CLK = 1'h0;
		RST = 1'h1;
		{LINK_DOWNGRADED, FC_UPDATE, FC_KIND, FC_HDR_ADD, FC_DATA_ADD,
			FC_HDR_INF, FC_DATA_INF, LINK_RX_VALID, LINK_RX_WORD} = '0;
		{AVS_ADDRESS, AVS_READ, AVS_WRITE, AVS_WRITEDATA} = '0;
		repeat (6) @(posedge CLK);
		RST <= 1'h0;
		xfer(1'h0, 4'h2, 32'h0);
		chk("unmapped", rd, 32'h0);
		chk("hdr_p", bus.header_credit_avail[0], 32'h000);
		fc(2'h0, 8'h04, 12'h008, 1'h0);
		chk("hdr_p", bus.header_credit_avail[0], 32'h004);
		chk("dat_p", bus.data_credit_avail[0], 32'h0008);
		cmd(2'h0, 8'h04, 1'h0, 1'h0);
		idle;
		chk("hdr_p", bus.header_credit_avail[0], 32'h003);
		chk("dat_p", bus.data_credit_avail[0], 32'h0004);
		chk("beats", n_val, 32'h4);
		chk("p_pulse", n_p, 32'h1);
		// Eight beats against four data credits must wait
		cmd(2'h0, 8'h08, 1'h0, 1'h0);
		repeat (20) @(posedge CLK);
		xfer(1'h0, `TCP_OFF_STATUS, 32'h0);
		chk("busy", rd[0], 1'h1);
		chk("held", n_val, 32'h4);
		fc(2'h0, 8'h00, 12'h008, 1'h0);
		idle;
		chk("dat_p", bus.data_credit_avail[0], 32'h0004);
		chk("p_pulse", n_p, 32'h2);
		cmd(2'h0, 8'h01, 1'h0, 1'h1);
		idle;
		chk("half", n_half, 32'h1);
		chk("hdr_p", bus.header_credit_avail[0], 32'h001);
		fc(2'h2, 8'h02, 12'h004, 1'h0);
		cmd(2'h2, 8'h02, 1'h1, 1'h0);
		idle;
		chk("abort", n_abt, 32'h1);
		chk("lasts", n_last, 32'h3);
		chk("dat_c", bus.data_credit_avail[2], 32'h0004);
		chk("c_pulse", n_c, 32'h0);
		cmd(2'h2, 8'h02, 1'h0, 1'h0);
		idle;
		chk("dat_c", bus.data_credit_avail[2], 32'h0002);
		chk("c_pulse", n_c, 32'h1);
		fc(2'h1, 8'h00, 12'h000, 1'h1);
		chk("hdr_np", bus.header_credit_avail[1], 32'h100);
		chk("dat_np", bus.data_credit_avail[1], 32'h1000);
		LINK_DOWNGRADED <= 1'h1;
		repeat (8) @(posedge CLK);
		e0 = n_en;
		repeat (40) @(posedge CLK);
		chk("enables", n_en - e0, 40 / DIV);
		e0 = n_val;
		cmd(2'h1, 8'h03, 1'h0, 1'h0);
		idle;
		chk("np_beats", n_val - e0, 32'h3);
		chk("tx_word", tx_w[31:0], 32'h02020202);
		LINK_DOWNGRADED <= 1'h0;
		LINK_RX_VALID <= 1'h1;
		LINK_RX_WORD <= 64'h0706050403020100;
		@(posedge CLK);
		LINK_RX_VALID <= 1'h0;
		xfer(1'h0, `TCP_OFF_RXWORD, 32'h0);
		chk("rx_top", rd, 32'h00010203);
		print_verdict;
	end
	// Tests need well under a thousand cycles
	initial begin
		repeat (4000) @(posedge CLK);
		bad_count++;
		print_verdict;
	end
endmodule : tb

// File: verification/tcp_props.sv
// Checker for the TLP send handshake and credit-change pulses
`timescale 1ns/100ps
module tcp_props (
	// Clock and reset
	input wire logic                     CLK,
	input wire logic                     RST,
	// Send handshake
	input wire logic                     tlp_send_request,
	input wire logic                     tlp_send_grant,
	input wire logic                     tlp_first_beat_in,
	input wire logic                     tlp_last_beat_in,
	input wire logic                     tlp_cancel_in,
	input wire logic                     beat_enable,
	input wire tcp_pkg::tcp_kind_t       tlp_kind,
	input wire logic [7:0]               hdr_need,
	input wire logic [11:0]              data_need,
	// Credit outputs
	input wire tcp_pkg::tcp_hdr_avail_t  header_credit_avail,
	input wire tcp_pkg::tcp_data_avail_t data_credit_avail,
	input wire logic                     posted_credit_changed,
	input wire logic                     completion_credit_changed
);
	logic fit;
	// Kind 3 never fits, so it can never be granted
	always_comb begin
		fit = 1'h0;
		if (tlp_kind != tcp_pkg::KIND_NONE)
			fit = (header_credit_avail[tlp_kind][8]
				|| header_credit_avail[tlp_kind][7:0] >= hdr_need)
				&& (data_credit_avail[tlp_kind][12]
				|| data_credit_avail[tlp_kind][11:0] >= data_need);
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_granted;
		tlp_send_request ##1 tlp_send_grant;
	endsequence
	sequence s_cut;
		tlp_cancel_in && beat_enable;
	endsequence
	// Fit is judged at the taking edge, a cycle before the grant
	chk_grant_fits: assert property (tlp_send_grant |-> $past(fit))
		else $error("grant without credits");
	chk_grant_pulse: assert property (
		tlp_send_grant |=> !tlp_send_grant)
		else $error("grant longer than a cycle");
	chk_first_next: assert property (s_granted |=> tlp_first_beat_in)
		else $error("first beat late");
	chk_posted_once: assert property (
		posted_credit_changed |=> !posted_credit_changed)
		else $error("posted pulse too long");
	chk_posted_debit: assert property (posted_credit_changed |->
		header_credit_avail[0][7:0]
		== $past(header_credit_avail[0][7:0]) - 8'h01)
		else $error("posted pulse without debit");
	chk_cpl_debit: assert property (completion_credit_changed |->
		header_credit_avail[2][7:0]
		== $past(header_credit_avail[2][7:0]) - 8'h01)
		else $error("completion pulse without debit");
	chk_cut_free: assert property (s_cut |=>
		!posted_credit_changed && !completion_credit_changed)
		else $error("cancelled TLP debited");
	chk_cut_nolast: assert property (
		tlp_cancel_in |-> !tlp_last_beat_in)
		else $error("cancel with last beat");
endmodule : tcp_props
